/* File: verilog/sfr_pkg.sv */
// Package: opcodes, field values, phase lengths and states of the fast-read block
package sfr_pkg;
  // Opcodes
  localparam logic [7:0] OP_FAST = 8'h0B;
  localparam logic [7:0] OP_DDR = 8'h0D;
  localparam logic [7:0] OP_DOUT = 8'h3B;
  localparam logic [7:0] OP_DIO = 8'hBB;
  // Mode byte patterns
  localparam logic [3:0] MODE_NIB = 4'hA;
  localparam logic [7:0] MODE_DDR = 8'hA5;
  // Address space
  localparam logic [18:0] ADDR_TOP = 19'h7FFFF;
  localparam logic [18:0] ADDR_ONE = 19'h00001;
  // Phase lengths in bits
  localparam logic [4:0] OPC_BITS = 5'h08;
  localparam logic [4:0] ADDR_BITS = 5'h18;
  localparam logic [4:0] MODE_BITS = 5'h08;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // Command protocol select
  localparam logic [1:0] PROTO_SPI = 2'h0;
  localparam logic [1:0] PROTO_DUAL = 2'h1;
  localparam logic [1:0] PROTO_QUAD = 2'h2;
  // Lane widths and output enables
  localparam logic [2:0] W1 = 3'h1;
  localparam logic [2:0] W2 = 3'h2;
  localparam logic [2:0] W4 = 3'h4;
  localparam logic [3:0] OE_W1 = 4'h2;
  localparam logic [3:0] OE_W2 = 4'h3;
  localparam logic [3:0] OE_W4 = 4'hF;
  // Pin synchroniser reset value, chip select idles high
  localparam logic [5:0] PIN_RST = 6'h01;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_OPC = 3'h1,
    ST_ADDR = 3'h2,
    ST_MODE = 3'h3,
    ST_DUMMY = 3'h4,
    ST_DATA = 3'h5,
    ST_IGN = 3'h6
  } sfr_state_t;
endpackage

/* File: verilog/sfr_sync.sv */
// Two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module sfr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= INIT;
      q <= INIT;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

/* File: verilog/sfr_tx.sv */
// Byte serialiser driving one, two or four data lanes
`timescale 1ns/1ps
module sfr_tx (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic clr,
  input wire logic step,
  input wire logic [2:0] w,
  input wire logic [7:0] din,
  // Lanes
  output logic [3:0] dout,
  output logic [3:0] oe,
  // Byte status
  output logic need_byte,
  output logic byte_end
);
  logic [7:0] sh_q;
  logic [3:0] cnt_q;
  logic [3:0] out_q;
  logic [3:0] oe_q;
  logic [7:0] src;
  logic [3:0] cnt_sum;
  logic [3:0] bits;
  logic [3:0] mask;

  assign need_byte = cnt_q == 4'h0;
  assign src = need_byte ? din : sh_q;
  assign cnt_sum = cnt_q + {1'b0, w};
  assign byte_end = step && (cnt_sum == sfr_pkg::BYTE_BITS);
  // Single lane drives the serial output line, the second lane
  assign bits = (w == sfr_pkg::W4) ? src[7:4] :
                (w == sfr_pkg::W2) ? {2'h0, src[7:6]} : {2'h0, src[7], 1'b0};
  assign mask = (w == sfr_pkg::W4) ? sfr_pkg::OE_W4 :
                (w == sfr_pkg::W2) ? sfr_pkg::OE_W2 : sfr_pkg::OE_W1;
  assign dout = out_q;
  assign oe = oe_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_q <= 8'h00;
      cnt_q <= 4'h0;
      out_q <= 4'h0;
      oe_q <= 4'h0;
    end else if (clr) begin
      cnt_q <= 4'h0;
      out_q <= 4'h0;
      oe_q <= 4'h0;
    end else if (step) begin
      sh_q <= src << w;
      cnt_q <= byte_end ? 4'h0 : cnt_sum;
      out_q <= bits;
      oe_q <= mask;
    end
  end
endmodule

/* File: verilog/sfr_read_core.sv */
// Serial memory fast-read command engine with opcode-skip continuous mode
//
// Overview of operation
// R1: After each data byte is shifted out, the read address steps up by one.
// R2: Address wraps from the top of the array back to zero, streaming on.
// R3: Single-rate fast read accepted in single, dual and quad command protocol.
// R4: Single-rate mode byte with upper nibble 1010 skips opcode in next frame.
// R5: Without continuous mode, each frame starts with an opcode.
// R6: A mode byte without the pattern leaves continuous mode.
// R7: Dummy cycle count comes from the latency code of configuration register one.
// R8: Double-rate read only in quad protocol; address, dummy, data on both edges.
// R9: Double-rate read enters continuous mode only on the exact full pattern.
// R10: Host keeps chip select low through double-rate dummy cycles.
// R11: Host uses clock idle-low mode for the double-rate read.
// R12: Two-line output read carries opcode to dummy on the single input line.
// R13: Two-line output read drives both lanes after last dummy, bit 7 on line one.
// R14: Two-line address read sends address two bits per clock, high bit line one.
// R15: Two-line address read outputs bit 7 on line one, bit 6 on line zero.
// R16: Only 19 address bits are decoded; upper bits of top byte ignored.
// R17: Data lines stay undriven while deselected and until output data begins.
`timescale 1ns/1ps
module sfr_read_core (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // Serial link pins
  input wire logic CS_N,
  input wire logic SCK,
  input wire logic [3:0] IO_IN,
  output logic [3:0] IO_OUT,
  output logic [3:0] IO_OE,
  // Configuration
  input wire logic [1:0] PROTO,
  input wire logic [3:0] LATENCY_CYCLE_CODE,
  // Array read port
  output logic [18:0] MEM_ADDR,
  input wire logic [7:0] MEM_DATA,
  // Status
  output logic XIP_ACTIVE
);
  ////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisation
  logic [1:0] rst_sr_q;
  logic rst_n;
  logic [5:0] pin_s;
  logic cs_n_s;
  logic sck_s;
  logic [3:0] io_s;
  logic cs_d_q;
  logic sck_d_q;

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rst_sr_q <= 2'h0;
    end else begin
      rst_sr_q <= {rst_sr_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sr_q[1];

  sfr_sync #(
    .W(6),
    .INIT(sfr_pkg::PIN_RST)
  ) u_pin_sync (
    .clk(CLOCK),
    .rst_n(rst_n),
    .d({IO_IN, SCK, CS_N}),
    .q(pin_s)
  );
  assign cs_n_s = pin_s[0];
  assign sck_s = pin_s[1];
  assign io_s = pin_s[5:2];

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      cs_d_q <= 1'b1;
      sck_d_q <= 1'b0;
    end else begin
      cs_d_q <= cs_n_s;
      sck_d_q <= sck_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  sfr_pkg::sfr_state_t state_q;
  sfr_pkg::sfr_state_t state_d;
  logic [7:0] cmd_q;
  logic [7:0] xip_cmd_q;
  logic xip_q;
  logic [23:0] sh_q;
  logic [4:0] bcnt_q;
  logic [4:0] dcnt_q;
  logic [18:0] addr_q;
  logic [2:0] pw;
  logic [2:0] w;
  logic rise;
  logic fall;
  logic cs_fall;
  logic ddr;
  logic beat;
  logic out_ev;
  logic [3:0] in_bits;
  logic [23:0] sh_d;
  logic [4:0] bnext;
  logic [4:0] plen;
  logic done;
  logic opc_done;
  logic addr_done;
  logic mode_done;
  logic op_ok;
  logic [7:0] op_byte;
  logic [7:0] mode_byte;
  logic [18:0] addr_in;
  logic mode_hit;
  logic [4:0] dum_tgt;
  logic dum_done;
  logic no_dummy;
  logic byte_end;
  logic need_byte;
  logic in_hdr;

  // Lane width of the current phase; opcodes always use the protocol width
  function automatic logic [2:0] lane_w(input sfr_pkg::sfr_state_t st,
      input logic [7:0] op, input logic [2:0] pwid);
    logic [2:0] r;
    r = pwid;
    if (st != sfr_pkg::ST_OPC) begin
      case (op)
        sfr_pkg::OP_DDR: r = sfr_pkg::W4;
        sfr_pkg::OP_DOUT: r = (st == sfr_pkg::ST_DATA) ? sfr_pkg::W2 : sfr_pkg::W1;
        sfr_pkg::OP_DIO: r = sfr_pkg::W2;
        default: r = pwid;
      endcase
    end
    return r;
  endfunction

  assign rise = sck_s & ~sck_d_q;
  assign fall = ~sck_s & sck_d_q;
  assign cs_fall = cs_d_q & ~cs_n_s;
  assign pw = (PROTO == sfr_pkg::PROTO_QUAD) ? sfr_pkg::W4 :
              (PROTO == sfr_pkg::PROTO_DUAL) ? sfr_pkg::W2 : sfr_pkg::W1;
  assign w = lane_w(state_q, cmd_q, pw); // [R12] [R14]
  assign in_hdr = (state_q == sfr_pkg::ST_OPC) || (state_q == sfr_pkg::ST_ADDR) ||
                  (state_q == sfr_pkg::ST_MODE);
  // Opcode stays single-rate; everything after it uses both edges
  // Fall that closes the last opcode clock carries no address bits
  assign ddr = (cmd_q == sfr_pkg::OP_DDR) && (state_q != sfr_pkg::ST_OPC) &&
               (state_q != sfr_pkg::ST_IDLE) &&
               !((state_q == sfr_pkg::ST_ADDR) && (bcnt_q == 5'h00)); // [R8]
  assign beat = !cs_n_s && (rise || (ddr && fall)); // [R8]
  assign out_ev = !cs_n_s && (state_q == sfr_pkg::ST_DATA) &&
                  (ddr ? (rise || fall) : fall); // [R13]
  assign in_bits = (w == sfr_pkg::W4) ? io_s :
                   (w == sfr_pkg::W2) ? {2'h0, io_s[1:0]} : {3'h0, io_s[0]}; // [R14]
  assign sh_d = (sh_q << w) | {20'h00000, in_bits};
  assign bnext = bcnt_q + {2'h0, w};
  assign plen = (state_q == sfr_pkg::ST_ADDR) ? sfr_pkg::ADDR_BITS :
                (state_q == sfr_pkg::ST_MODE) ? sfr_pkg::MODE_BITS : sfr_pkg::OPC_BITS;
  assign done = beat && in_hdr && (bnext == plen);
  assign opc_done = done && (state_q == sfr_pkg::ST_OPC);
  assign addr_done = done && (state_q == sfr_pkg::ST_ADDR);
  assign mode_done = done && (state_q == sfr_pkg::ST_MODE);
  assign op_byte = sh_d[7:0];
  assign mode_byte = sh_d[7:0];
  assign addr_in = sh_d[18:0]; // [R16]
  assign op_ok = (op_byte == sfr_pkg::OP_FAST) ||
                 ((op_byte == sfr_pkg::OP_DDR) && (PROTO == sfr_pkg::PROTO_QUAD)) ||
                 (((op_byte == sfr_pkg::OP_DOUT) || (op_byte == sfr_pkg::OP_DIO)) &&
                  (PROTO == sfr_pkg::PROTO_SPI)); // [R3] [R8]
  // Double-rate needs the full byte, the others only the upper nibble
  assign mode_hit = (cmd_q == sfr_pkg::OP_DDR) ? (mode_byte == sfr_pkg::MODE_DDR) :
                    (mode_byte[7:4] == sfr_pkg::MODE_NIB); // [R4] [R6] [R9]
  // Dummy counted in clocks; double-rate samples two beats per clock
  assign dum_tgt = ddr ? {LATENCY_CYCLE_CODE, 1'b0} : {1'b0, LATENCY_CYCLE_CODE}; // [R7]
  assign no_dummy = LATENCY_CYCLE_CODE == 4'h0;
  assign dum_done = beat && (state_q == sfr_pkg::ST_DUMMY) &&
                    ((dcnt_q + 5'h01) == dum_tgt); // [R7]

  ////////////////////////////////////////////////////////////////////////////
  // Phase sequencing
  always_comb begin
    state_d = state_q;
    case (state_q)
      sfr_pkg::ST_IDLE: if (cs_fall) begin
        state_d = xip_q ? sfr_pkg::ST_ADDR : sfr_pkg::ST_OPC; // [R4] [R5]
      end
      sfr_pkg::ST_OPC: if (opc_done) begin
        state_d = op_ok ? sfr_pkg::ST_ADDR : sfr_pkg::ST_IGN;
      end
      sfr_pkg::ST_ADDR: if (addr_done) begin
        state_d = sfr_pkg::ST_MODE;
      end
      sfr_pkg::ST_MODE: if (mode_done) begin
        state_d = no_dummy ? sfr_pkg::ST_DATA : sfr_pkg::ST_DUMMY;
      end
      sfr_pkg::ST_DUMMY: if (dum_done) begin
        state_d = sfr_pkg::ST_DATA;
      end
      sfr_pkg::ST_DATA: state_d = state_q;
      sfr_pkg::ST_IGN: state_d = state_q;
      default: state_d = sfr_pkg::ST_IDLE;
    endcase
    // Deselect ends any frame, even inside dummy cycles
    if (cs_n_s) begin
      state_d = sfr_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= sfr_pkg::ST_IDLE;
      bcnt_q <= 5'h00;
      dcnt_q <= 5'h00;
      sh_q <= 24'h000000;
    end else begin
      state_q <= state_d;
      bcnt_q <= (state_d != state_q) ? 5'h00 : (beat && in_hdr) ? bnext : bcnt_q;
      dcnt_q <= (state_d != state_q) ? 5'h00 : (dum_done || !beat) ? dcnt_q :
                dcnt_q + 5'h01;
      if (beat && in_hdr) begin
        sh_q <= sh_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command, continuous mode and address
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      cmd_q <= 8'h00;
      xip_cmd_q <= 8'h00;
      xip_q <= 1'b0;
    end else if (state_q == sfr_pkg::ST_IDLE && cs_fall && xip_q) begin
      cmd_q <= xip_cmd_q; // [R4]
    end else if (opc_done) begin
      cmd_q <= op_byte;
    end else if (mode_done) begin
      xip_q <= mode_hit; // [R4] [R6] [R9]
      xip_cmd_q <= cmd_q;
    end
  end

  // Address is a flop so the array sees a stable index all byte long
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= 19'h00000;
    end else if (addr_done) begin
      addr_q <= addr_in; // [R16]
    end else if (byte_end) begin
      addr_q <= addr_q + sfr_pkg::ADDR_ONE; // [R1] [R2]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output lanes
  sfr_tx u_tx (
    .clk(CLOCK),
    .rst_n(rst_n),
    .clr(cs_n_s || (state_q != sfr_pkg::ST_DATA)), // [R17]
    .step(out_ev), // [R13] [R15]
    .w(w),
    .din(MEM_DATA),
    .dout(IO_OUT),
    .oe(IO_OE),
    .need_byte(need_byte),
    .byte_end(byte_end)
  );

  assign MEM_ADDR = addr_q;
  assign XIP_ACTIVE = xip_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!rst_n);

  AST_ADDR_STEP: assert property ( // [R1]
    byte_end && (addr_q != sfr_pkg::ADDR_TOP) |=> addr_q == $past(addr_q) + sfr_pkg::ADDR_ONE)
    else $error("read address did not step after a byte");
  AST_ADDR_WRAP: assert property ( // [R2]
    byte_end && (addr_q == sfr_pkg::ADDR_TOP) |=> addr_q == 19'h00000)
    else $error("read address did not wrap to zero");
  AST_FAST_ACCEPT: assert property ( // [R3]
    opc_done && (op_byte == sfr_pkg::OP_FAST) |=> state_q == sfr_pkg::ST_ADDR)
    else $error("fast read opcode not accepted");
  AST_XIP_SKIP: assert property ( // [R4]
    (state_q == sfr_pkg::ST_IDLE) && cs_fall && xip_q |=>
      (state_q == sfr_pkg::ST_ADDR) && (cmd_q == $past(xip_cmd_q)))
    else $error("continuous mode frame did not start at address");
  AST_OPC_FIRST: assert property ( // [R5]
    (state_q == sfr_pkg::ST_IDLE) && cs_fall && !xip_q |=> state_q == sfr_pkg::ST_OPC)
    else $error("frame did not expect an opcode");
  AST_XIP_LEAVE: assert property ( // [R6]
    mode_done && (cmd_q != sfr_pkg::OP_DDR) && (mode_byte[7:4] != sfr_pkg::MODE_NIB)
      |=> !xip_q)
    else $error("continuous mode kept after a plain mode byte");
  AST_DUMMY_LEN: assert property ( // [R7]
    (state_q == sfr_pkg::ST_DUMMY) && (state_d == sfr_pkg::ST_DATA) |->
      beat && (dcnt_q + 5'h01 == dum_tgt))
    else $error("dummy phase length does not match latency code");
  AST_DDR_QUAD: assert property ( // [R8]
    opc_done && (op_byte == sfr_pkg::OP_DDR) && (PROTO != sfr_pkg::PROTO_QUAD)
      |=> state_q == sfr_pkg::ST_IGN)
    else $error("double-rate read taken outside quad protocol");
  AST_DDR_MODE: assert property ( // [R9]
    mode_done && (cmd_q == sfr_pkg::OP_DDR) |=>
      xip_q == ($past(mode_byte) == sfr_pkg::MODE_DDR))
    else $error("double-rate continuous mode decision wrong");
  AST_DOUT_SERIAL: assert property ( // [R12]
    in_hdr && (cmd_q == sfr_pkg::OP_DOUT) && (state_q != sfr_pkg::ST_OPC) |-> w == sfr_pkg::W1)
    else $error("two-line output read header not on one line");
  AST_DUAL_DATA: assert property ( // [R13]
    (state_q == sfr_pkg::ST_DATA) && ((cmd_q == sfr_pkg::OP_DOUT) ||
      (cmd_q == sfr_pkg::OP_DIO)) && (IO_OE != 4'h0) |-> IO_OE == sfr_pkg::OE_W2)
    else $error("two-line read data not on two lanes");
  AST_DIO_ADDR: assert property ( // [R14]
    (state_q == sfr_pkg::ST_ADDR) && (cmd_q == sfr_pkg::OP_DIO) |-> w == sfr_pkg::W2)
    else $error("two-line address not taken two bits per clock");
  AST_DIO_ORDER: assert property ( // [R15]
    out_ev && need_byte && (w == sfr_pkg::W2) |=> IO_OUT[1:0] == $past(MEM_DATA[7:6]))
    else $error("two-line data not led by bits 7 and 6");
  AST_ADDR_CUT: assert property ( // [R16]
    addr_done |=> addr_q == $past(addr_in))
    else $error("address not taken from low 19 bits");
  AST_QUIET: assert property ( // [R17]
    cs_n_s || in_hdr || (state_q == sfr_pkg::ST_DUMMY) |=> IO_OE == 4'h0)
    else $error("data lines driven outside data phase");

  COV_XIP_SKIP: cover property ((state_q == sfr_pkg::ST_IDLE) && cs_fall && xip_q);
  COV_DDR_DATA: cover property (out_ev && (cmd_q == sfr_pkg::OP_DDR));
  COV_DUAL_DATA: cover property (out_ev && (cmd_q == sfr_pkg::OP_DIO));
  COV_WRAP: cover property (byte_end && (addr_q == sfr_pkg::ADDR_TOP));
endmodule

/* File: tb/sfr_host_model.sv */
// Host model that frames serial reads into the fast-read block
`timescale 1ns/1ps
module sfr_host_model (
  // Clock
  input wire logic clk,
  // Link pins
  output logic cs_n,
  output logic sck,
  output logic [3:0] hio,
  output logic [3:0] hoe,
  input wire logic [3:0] pin,
  input wire logic [3:0] dev_oe
);
  logic [3:0] smp;
  logic act;

  initial begin
    cs_n = 1'b1;
    sck = 1'b0; // Clock idles low, mode 0 only
    hio = 4'h0;
    hoe = 4'h0;
    smp = 4'h0;
    act = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data moves mid half period, well clear of the block's sync window
  task automatic step(input logic [3:0] v, input logic [3:0] oe);
    repeat (2) @(posedge clk);
    hio <= v;
    hoe <= oe;
    repeat (2) @(posedge clk);
    sck <= ~sck;
    #1;
    smp = pin;
    act = act | (dev_oe != 4'h0);
  endtask

  task automatic send(input logic [31:0] val, input int n, input int w, input logic ddr);
    logic [3:0] oe;
    logic [3:0] v;
    oe = (w == 1) ? 4'h1 : ((w == 2) ? 4'h3 : 4'hF);
    for (int i = n - w; i >= 0; i -= w) begin
      v = 4'((val >> i) & ((32'h1 << w) - 32'h1));
      step(v, oe); // Both edges carry bits in double rate
      if (!ddr) step(v, oe);
    end
  endtask

  task automatic frame(input logic skip, input logic [7:0] op, input int wop,
                       input logic [23:0] adr, input int wa, input logic ddr,
                       input logic [7:0] md, input int dmy, input int wd, input int nb,
                       output logic [7:0] got [8], output logic pre, output logic post);
    logic [7:0] b;
    @(posedge clk);
    cs_n <= 1'b0;
    act = 1'b0;
    repeat (4) @(posedge clk);
    if (!skip) send({24'h0, op}, 8, wop, 1'b0);
    send({8'h0, adr}, 24, wa, ddr);
    send({24'h0, md}, 8, wa, ddr);
    for (int i = 0; i < 2 * dmy; i++) step(4'h0, 4'h0); // Chip select held low
    pre = act;
    if (ddr) step(4'h0, 4'h0);
    for (int k = 0; k < nb; k++) begin
      b = 8'h00;
      for (int j = 0; j < 8; j += wd) begin
        step(4'h0, 4'h0);
        b = (wd == 1) ? {b[6:0], smp[1]} : ((wd == 2) ? {b[5:0], smp[1:0]} : {b[3:0], smp});
        if (!ddr) step(4'h0, 4'h0);
      end
      got[k] = b;
    end
    post = act;
    if (sck) step(4'h0, 4'h0); // Park the clock low before deselect
    @(posedge clk);
    cs_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
endmodule

/* File: tb/sfr_read_core_bench.sv */
// Self-checking bench of the fast-read block with host and array models
`timescale 1ns/1ps
module sfr_read_core_bench;
  logic clock;
  logic rst_n;
  logic [1:0] proto;
  logic [3:0] lat;
  logic idle_q;
  logic cs_n;
  logic sck;
  logic [3:0] hio;
  logic [3:0] hoe;
  logic [3:0] io_out;
  logic [3:0] io_oe;
  logic [3:0] pin;
  logic [18:0] mem_addr;
  logic [7:0] mem_data;
  logic armed;
  logic [7:0] got [8];
  logic pre;
  logic post;
  int errors;
  int cmp_count;

  function automatic logic [7:0] pat(input logic [18:0] a);
    return a[7:0] ^ a[15:8] ^ {5'h00, a[18:16]};
  endfunction

  // Undriven lines toggle every cycle so a stale value never looks right
  assign pin = (io_oe & io_out) | (~io_oe & hoe & hio) | (~io_oe & ~hoe & {4{idle_q}});
  assign mem_data = pat(mem_addr);

  sfr_read_core uut (.CLOCK(clock), .RST_N(rst_n), .CS_N(cs_n), .SCK(sck), .IO_IN(pin),
    .IO_OUT(io_out), .IO_OE(io_oe), .PROTO(proto), .LATENCY_CYCLE_CODE(lat),
    .MEM_ADDR(mem_addr), .MEM_DATA(mem_data), .XIP_ACTIVE(armed));

  sfr_host_model host (.clk(clock), .cs_n(cs_n), .sck(sck), .hio(hio), .hoe(hoe),
    .pin(pin), .dev_oe(io_oe));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  always @(posedge clock) idle_q <= ~idle_q;

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [18:0] exp, input logic [18:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rd(input logic [1:0] p, input logic skip, input logic [7:0] op,
                    input logic [23:0] adr, input logic [7:0] md, input int dmy, input int nb);
    int wp;
    int wa;
    int wd;
    wp = (p == 2'h1) ? 2 : ((p == 2'h2) ? 4 : 1);
    wa = (op == sfr_pkg::OP_DDR) ? 4 : ((op == sfr_pkg::OP_DOUT) ? 1 : wp);
    wa = (op == sfr_pkg::OP_DIO) ? 2 : wa;
    wd = (op == sfr_pkg::OP_FAST) ? wp : ((op == sfr_pkg::OP_DDR) ? 4 : 2);
    @(posedge clock);
    proto <= p;
    lat <= 4'(dmy);
    host.frame(skip, op, wp, adr, wa, op == sfr_pkg::OP_DDR, md, dmy, wd, nb, got, pre, post);
  endtask

  task automatic cmp_data(input logic [18:0] a, input int nb);
    for (int k = 0; k < nb; k++) check("data", 19'(pat(a + 19'(k))), 19'(got[k]));
    check("early drive", 19'h0, 19'(pre));
    check("idle drive", 19'h0, 19'(io_oe));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_fast();
    for (int p = 0; p < 3; p++) begin
      rd(2'(p), 1'b0, sfr_pkg::OP_FAST, 24'h012340 + 24'(p * 16), 8'h00, p, 3);
      cmp_data(19'h12340 + 19'(p * 16), 3);
    end
    $display("t_fast done");
  endtask

  task automatic t_wrap();
    rd(2'h0, 1'b0, sfr_pkg::OP_FAST, 24'hFFFFFE, 8'h00, 1, 4);
    cmp_data(19'h7FFFE, 4);
    check("address after wrap", 19'h00002, mem_addr);
    $display("t_wrap done");
  endtask

  task automatic t_skip_sdr();
    rd(2'h1, 1'b0, sfr_pkg::OP_FAST, 24'h000100, 8'hA3, 2, 2);
    cmp_data(19'h00100, 2);
    check("armed", 19'h1, 19'(armed));
    rd(2'h1, 1'b1, sfr_pkg::OP_FAST, 24'h000200, 8'h5A, 2, 2);
    cmp_data(19'h00200, 2);
    check("disarmed", 19'h0, 19'(armed));
    rd(2'h1, 1'b0, sfr_pkg::OP_FAST, 24'h000300, 8'h00, 2, 2);
    cmp_data(19'h00300, 2);
    $display("t_skip_sdr done");
  endtask

  task automatic t_ddr();
    rd(2'h2, 1'b0, sfr_pkg::OP_DDR, 24'h001000, 8'hA4, 2, 2);
    cmp_data(19'h01000, 2);
    check("near pattern", 19'h0, 19'(armed));
    rd(2'h2, 1'b0, sfr_pkg::OP_DDR, 24'h002000, 8'hA5, 1, 2);
    cmp_data(19'h02000, 2);
    check("full pattern", 19'h1, 19'(armed));
    rd(2'h2, 1'b1, sfr_pkg::OP_DDR, 24'h003000, 8'h00, 3, 2);
    cmp_data(19'h03000, 2);
    check("ddr exit", 19'h0, 19'(armed));
    $display("t_ddr done");
  endtask

  task automatic t_dual();
    rd(2'h0, 1'b0, sfr_pkg::OP_DOUT, 24'h004000, 8'hA0, 1, 3);
    cmp_data(19'h04000, 3);
    check("dout armed", 19'h1, 19'(armed));
    rd(2'h0, 1'b1, sfr_pkg::OP_DOUT, 24'h004800, 8'hFF, 0, 2);
    cmp_data(19'h04800, 2);
    rd(2'h0, 1'b0, sfr_pkg::OP_DIO, 24'h005000, 8'hA7, 2, 3);
    cmp_data(19'h05000, 3);
    rd(2'h0, 1'b1, sfr_pkg::OP_DIO, 24'h006000, 8'h00, 1, 2);
    cmp_data(19'h06000, 2);
    check("dio exit", 19'h0, 19'(armed));
    $display("t_dual done");
  endtask

  task automatic t_refuse();
    rd(2'h0, 1'b0, sfr_pkg::OP_DDR, 24'h007000, 8'hA5, 1, 2);
    check("ddr in single", 19'h0, 19'({post, armed}));
    rd(2'h2, 1'b0, sfr_pkg::OP_DOUT, 24'h007000, 8'hA0, 1, 2);
    check("dout in quad", 19'h0, 19'({post, armed}));
    $display("t_refuse done");
  endtask

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    proto = 2'h0;
    lat = 4'h0;
    idle_q = 1'b0;
    errors = 0;
    cmp_count = 0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    repeat (8) @(posedge clock);
    t_fast();
    t_wrap();
    t_skip_sdr();
    t_ddr();
    t_dual();
    t_refuse();
    test_done();
  end

  // Full run needs about 4400 cycles
  initial begin
    repeat (40000) @(posedge clock);
    errors++;
    test_done();
  end
endmodule
